// ==== src/ims_ctrl.v ====
// two-wire bus master and addressed slave controller
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "ims_consts.vh"
module ims_ctrl #(
  parameter BRGW = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata_q,
  input wire cpu_idle,
  input wire scl_in,
  output reg scl_out_q,
  output reg scl_oe_q,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  output reg pin_owner_q,
  output reg slv_evt_q
);
  localparam M_IDLE = 3'h0;
  localparam M_START = 3'h1;
  localparam M_RSTART = 3'h2;
  localparam M_STOP = 3'h3;
  localparam M_TX = 3'h4;
  localparam M_RX = 3'h5;
  localparam M_ACK = 3'h6;
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_ADR2 = 3'h2;
  localparam S_RX = 3'h3;
  localparam S_TX = 3'h4;
  localparam S_IGN = 3'h5;

  // ==================================================
  // state
  reg [15:0] ctl_q;
  reg [1:0] cth_q;
  reg [9:0] msk_q;
  reg [9:0] own_q;
  reg [BRGW-1:0] brg_q;
  reg [BRGW:0] brg_cnt_q;
  reg [7:0] tx_q;
  reg [7:0] rx_q;
  reg ackst_q, gc_q, a10_q, tx_write_clash_q, ov_q, da_q, p_q, s_q, rw_q, rbf_q, tbf_q;
  reg [2:0] m_st_q;
  reg [4:0] m_cnt_q;
  reg [7:0] m_sh_q;
  reg m_scl_q, m_sda_q, own_bus_q;
  reg [2:0] s_st_q;
  reg [2:0] s_nxt_q;
  reg [3:0] s_bit_q;
  reg [7:0] s_sh_q;
  reg s_sda_q, s_scl_q, s_nak_q, s_wait_q;
  reg [1:0] s_pnd_q;
  reg scl_p_q, sda_p_q, sda_dly_q;
  reg [15:0] rd_d;

  wire on = ctl_q[`IMS_B_ON];
  wire run = on & ~(ctl_q[`IMS_B_IDL] & cpu_idle);
  wire strict = ctl_q[`IMS_B_GRD];
  wire ten = ctl_q[`IMS_B_A10];
  wire start_det = scl_in & scl_p_q & sda_p_q & ~sda_in;
  wire stop_det = scl_in & scl_p_q & ~sda_p_q & sda_in;
  wire scl_rise = scl_in & ~scl_p_q;
  wire scl_fall = ~scl_in & scl_p_q;
  wire busy = (m_st_q != M_IDLE) | tbf_q;

  // ==================================================
  // rate generator
  // a slave holding the clock low keeps reloading the count
  wire hold = ~scl_oe_q & ~scl_in & ~m_scl_q;
  wire tick = run & (brg_cnt_q == {(BRGW+1){1'b0}}) & ~hold;
  wire [BRGW:0] reload = {1'b0, brg_q} + {{BRGW{1'b0}}, 1'b1};

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      brg_cnt_q <= {(BRGW+1){1'b0}};
    else if (!run)
      brg_cnt_q <= {(BRGW+1){1'b0}};
    else if (hold || tick)
      brg_cnt_q <= reload;
    else
      brg_cnt_q <= brg_cnt_q - {{BRGW{1'b0}}, 1'b1};
  end

  // ==================================================
  // slave address match
  wire [9:0] mske = strict ? 10'h000 : msk_q;
  wire [6:0] a7 = s_sh_q[7:1];
  wire hdr = (a7[6:2] == `IMS_HDR10);
  wire rsv = (a7[6:3] == 4'h0) | (a7[6:3] == 4'hf);
  wire m7 = ~|((a7 ^ own_q[6:0]) & ~mske[6:0]);
  wire mh = hdr & ~|((a7[1:0] ^ own_q[9:8]) & ~mske[9:8]);
  wire m10 = ~|((s_sh_q ^ own_q[7:0]) & ~mske[7:0]);
  wire gcb = (s_sh_q == `IMS_GC_ADDR);
  wire rsv_ok = rsv & ~hdr & ~strict;
  wire a_ok = gcb ? ctl_q[`IMS_B_GCA] :
    ten ? ((mh & (~s_sh_q[0] | a10_q)) | rsv_ok) : (rsv_ok | (~rsv & m7));
  wire s_act = (s_st_q != S_IDLE) & (s_st_q != S_IGN);

  // ==================================================
  // read mux
  always @*
  begin
    rd_d = 16'h0000;
    case (addr)
      `IMS_A_CTLL: rd_d = ctl_q;
      `IMS_A_CTLH: rd_d = {14'h0000, cth_q};
      `IMS_A_STAT: rd_d = {ackst_q, m_st_q == M_TX, 4'h0, gc_q, a10_q,
                           tx_write_clash_q, ov_q, da_q, p_q, s_q, rw_q, rbf_q, tbf_q};
      `IMS_A_MSK: rd_d = {6'h00, msk_q};
      `IMS_A_BRG: rd_d = brg_q;
      `IMS_A_ADD: rd_d = {6'h00, own_q};
      `IMS_A_TRN: rd_d = {8'h00, tx_q};
      `IMS_A_RCV: rd_d = {8'h00, rx_q};
      default: rd_d = 16'h0000;
    endcase
  end

  // ==================================================
  // registers, master and slave engines
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_q <= `IMS_CTLL_RST;
      cth_q <= 2'h0;
      msk_q <= 10'h000;
      own_q <= 10'h000;
      brg_q <= {BRGW{1'b0}};
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      {ackst_q, gc_q, a10_q, tx_write_clash_q, ov_q, da_q} <= 6'h00;
      {p_q, s_q, rw_q, rbf_q, tbf_q} <= 5'h00;
      m_st_q <= M_IDLE;
      m_cnt_q <= 5'h00;
      m_sh_q <= 8'h00;
      {m_scl_q, m_sda_q, own_bus_q} <= 3'h0;
      s_st_q <= S_IDLE;
      s_nxt_q <= S_IDLE;
      s_bit_q <= 4'h0;
      s_sh_q <= 8'h00;
      {s_sda_q, s_scl_q, s_nak_q, s_wait_q} <= 4'h0;
      s_pnd_q <= 2'h0;
      {scl_p_q, sda_p_q} <= 2'h3;
      {sda_dly_q, sda_oe_q, scl_oe_q, sda_out_q, scl_out_q} <= 5'h00;
      pin_owner_q <= 1'b0;
      slv_evt_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      scl_p_q <= scl_in;
      sda_p_q <= sda_in;
      slv_evt_q <= 1'b0;
      rdata_q <= rd_stb ? rd_d : 16'h0000;
      if (rd_stb && addr == `IMS_A_RCV)
        rbf_q <= 1'b0;
      if (wr_stb)
      begin
        case (addr)
          `IMS_A_CTLL:
          begin
            ctl_q <= wdata & `IMS_CTLL_MSK;
            // a written zero stretches only when allowed
            ctl_q[`IMS_B_REL] <= wdata[`IMS_B_REL] | (~ctl_q[`IMS_B_SCE] & ctl_q[`IMS_B_REL]);
          end
          `IMS_A_CTLH: cth_q <= wdata[1:0];
          `IMS_A_STAT:
          begin
            if (!wdata[`IMS_B_CLSH])
              tx_write_clash_q <= 1'b0;
            if (!wdata[`IMS_B_OVF])
              ov_q <= 1'b0;
          end
          `IMS_A_MSK: msk_q <= wdata[9:0];
          `IMS_A_BRG: brg_q <= wdata[BRGW-1:0];
          `IMS_A_ADD: own_q <= wdata[9:0];
          `IMS_A_TRN:
          begin
            if (busy)
              tx_write_clash_q <= 1'b1;
            else
            begin
              tx_q <= wdata[7:0];
              tbf_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (run && start_det)
      begin
        s_q <= 1'b1;
        p_q <= 1'b0;
      end
      if (run && stop_det)
      begin
        p_q <= 1'b1;
        s_q <= 1'b0;
      end
      // master: one step per half-period tick
      if (tick)
      begin
        case (m_st_q)
          M_IDLE:
          begin
            m_cnt_q <= 5'h00;
            if (ctl_q[`IMS_B_SRQ])
              m_st_q <= M_START;
            else if (ctl_q[`IMS_B_RSR])
              m_st_q <= M_RSTART;
            else if (ctl_q[`IMS_B_SPR])
              m_st_q <= M_STOP;
            else if (ctl_q[`IMS_B_RXR])
            begin
              m_st_q <= M_RX;
              m_sda_q <= 1'b0;
            end
            else if (ctl_q[`IMS_B_AKR])
            begin
              m_st_q <= M_ACK;
              m_sda_q <= ~ctl_q[`IMS_B_AKV];
            end
            else if (tbf_q && own_bus_q)
            begin
              m_st_q <= M_TX;
              m_sh_q <= tx_q;
              m_sda_q <= ~tx_q[7];
            end
          end
          M_START:
          begin
            m_cnt_q <= m_cnt_q + 5'h01;
            if (m_cnt_q == 5'h00)
              m_sda_q <= 1'b1;
            else
            begin
              m_scl_q <= 1'b1;
              own_bus_q <= 1'b1;
              ctl_q[`IMS_B_SRQ] <= 1'b0;
              m_st_q <= M_IDLE;
            end
          end
          M_RSTART:
          begin
            m_cnt_q <= m_cnt_q + 5'h01;
            case (m_cnt_q)
              5'h00: m_sda_q <= 1'b0;
              5'h01: m_scl_q <= 1'b0;
              5'h02: m_sda_q <= 1'b1;
              default:
              begin
                m_scl_q <= 1'b1;
                ctl_q[`IMS_B_RSR] <= 1'b0;
                m_st_q <= M_IDLE;
              end
            endcase
          end
          M_STOP:
          begin
            m_cnt_q <= m_cnt_q + 5'h01;
            case (m_cnt_q)
              5'h00: m_sda_q <= 1'b1;
              5'h01: m_scl_q <= 1'b0;
              default:
              begin
                m_sda_q <= 1'b0;
                own_bus_q <= 1'b0;
                ctl_q[`IMS_B_SPR] <= 1'b0;
                m_st_q <= M_IDLE;
              end
            endcase
          end
          M_TX, M_RX, M_ACK:
          begin
            m_cnt_q <= m_cnt_q + 5'h01;
            if (!m_cnt_q[0])
              m_scl_q <= 1'b0;
            else
            begin
              m_scl_q <= 1'b1;
              if (m_st_q == M_ACK)
              begin
                m_sda_q <= 1'b0;
                ctl_q[`IMS_B_AKR] <= 1'b0;
                m_st_q <= M_IDLE;
              end
              else if (m_st_q == M_RX)
              begin
                m_sh_q <= {m_sh_q[6:0], sda_in};
                if (m_cnt_q[4:1] == 4'h7)
                begin
                  rx_q <= {m_sh_q[6:0], sda_in};
                  rbf_q <= 1'b1;
                  if (rbf_q)
                    ov_q <= 1'b1;
                  ctl_q[`IMS_B_RXR] <= 1'b0;
                  m_st_q <= M_IDLE;
                end
              end
              else if (m_cnt_q[4:1] == 4'h8)
              begin
                ackst_q <= sda_in;
                tbf_q <= 1'b0;
                m_st_q <= M_IDLE;
              end
              else
              begin
                m_sh_q <= {m_sh_q[6:0], 1'b0};
                m_sda_q <= (m_cnt_q[4:1] == 4'h7) ? 1'b0 : ~m_sh_q[6];
              end
            end
          end
          default: m_st_q <= M_IDLE;
        endcase
      end
      // slave: follows the line edges
      if (run && !own_bus_q)
      begin
        s_scl_q <= s_act & (~ctl_q[`IMS_B_REL] | (|s_pnd_q)) & (s_scl_q | ~scl_in);
        if (s_pnd_q[1])
          s_pnd_q <= 2'h0;
        else if (s_pnd_q[0] && ctl_q[`IMS_B_REL])
        begin
          // two-step release keeps data settled before the clock rises
          s_sda_q <= ~ctl_q[`IMS_B_AKV];
          s_nak_q <= ctl_q[`IMS_B_AKV];
          s_pnd_q <= 2'h2;
        end
        if (start_det)
        begin
          s_st_q <= S_ADDR;
          s_bit_q <= 4'h0;
          s_sda_q <= 1'b0;
          s_pnd_q <= 2'h0;
        end
        else if (stop_det)
        begin
          s_st_q <= S_IDLE;
          gc_q <= 1'b0;
          a10_q <= 1'b0;
          s_sda_q <= 1'b0;
        end
        else if (s_st_q == S_TX)
        begin
          if (!scl_in)
            s_sda_q <= s_bit_q[3] ? 1'b0 : ~tx_q[3'h7 - s_bit_q[2:0]];
          if (scl_rise)
          begin
            if (s_bit_q != 4'h8)
              s_bit_q <= s_bit_q + 4'h1;
            else
            begin
              tbf_q <= 1'b0;
              s_bit_q <= 4'h0;
              if (sda_in)
                s_st_q <= S_IGN;
              else
                ctl_q[`IMS_B_REL] <= 1'b0;
            end
          end
        end
        else if (s_act)
        begin
          if (scl_rise && !s_bit_q[3])
          begin
            s_sh_q <= {s_sh_q[6:0], sda_in};
            s_bit_q <= s_bit_q + 4'h1;
          end
          if (scl_fall && s_bit_q == 4'h9)
          begin
            s_sda_q <= 1'b0;
            s_bit_q <= 4'h0;
            s_st_q <= s_nak_q ? S_IGN : s_nxt_q;
            if (s_nxt_q == S_TX && !s_nak_q)
              ctl_q[`IMS_B_REL] <= 1'b0;
          end
          else if (scl_fall && s_bit_q == 4'h8)
          begin
            s_bit_q <= 4'h9;
            s_nak_q <= 1'b0;
            s_wait_q <= (s_st_q == S_RX) ? cth_q[`IMS_B_DHLD] : cth_q[`IMS_B_AHLD];
            if (s_st_q == S_RX)
            begin
              rx_q <= s_sh_q;
              rbf_q <= 1'b1;
              if (rbf_q)
                ov_q <= 1'b1;
              da_q <= 1'b1;
              slv_evt_q <= 1'b1;
              s_nxt_q <= S_RX;
              if (cth_q[`IMS_B_DHLD])
              begin
                ctl_q[`IMS_B_REL] <= 1'b0;
                s_pnd_q <= 2'h1;
              end
              else
              begin
                s_sda_q <= ~rbf_q;
                s_nak_q <= rbf_q;
                if (ctl_q[`IMS_B_SCE])
                  ctl_q[`IMS_B_REL] <= 1'b0;
              end
            end
            else if ((s_st_q == S_ADDR && a_ok) || (s_st_q == S_ADR2 && m10))
            begin
              da_q <= 1'b0;
              slv_evt_q <= 1'b1;
              if (s_st_q == S_ADR2)
              begin
                a10_q <= 1'b1;
                s_nxt_q <= S_RX;
              end
              else
              begin
                rw_q <= s_sh_q[0];
                gc_q <= gcb;
                s_nxt_q <= gcb ? S_RX : (ten & hdr & ~s_sh_q[0]) ? S_ADR2 : s_sh_q[0] ? S_TX : S_RX;
              end
              if (cth_q[`IMS_B_AHLD])
              begin
                ctl_q[`IMS_B_REL] <= 1'b0;
                s_pnd_q <= 2'h1;
              end
              else
                s_sda_q <= 1'b1;
            end
            else
              s_st_q <= S_IGN;
          end
        end
      end
      // disabled: both pins back to port control
      if (!on)
      begin
        ctl_q[`IMS_B_REL] <= 1'b1;
        ctl_q[4:0] <= 5'h00;
        m_st_q <= M_IDLE;
        s_st_q <= S_IDLE;
        {m_scl_q, m_sda_q, own_bus_q, s_sda_q, s_scl_q} <= 5'h00;
        s_pnd_q <= 2'h0;
        {p_q, s_q} <= 2'h0;
      end
      // extra flop on data gives hold time after the clock falls
      sda_dly_q <= on & (m_sda_q | s_sda_q);
      sda_oe_q <= on & sda_dly_q;
      scl_oe_q <= on & (m_scl_q | s_scl_q);
      pin_owner_q <= on;
      sda_out_q <= 1'b0;
      scl_out_q <= 1'b0;
    end
  end
endmodule // ims_ctrl

// ==== src/ims_consts.vh ====
// constants and register map of the two-wire bus controller
`ifndef IMS_CONSTS_VH
`define IMS_CONSTS_VH

// ==================================================
// register indices
`define IMS_A_CTLL 3'h0
`define IMS_A_CTLH 3'h1
`define IMS_A_STAT 3'h2
`define IMS_A_MSK 3'h3
`define IMS_A_BRG 3'h4
`define IMS_A_ADD 3'h5
`define IMS_A_TRN 3'h6
`define IMS_A_RCV 3'h7
// ==================================================
// control_low fields and reset value
`define IMS_CTLL_RST 16'h1000
`define IMS_CTLL_MSK 16'hbcff
`define IMS_B_ON 15
`define IMS_B_IDL 13
`define IMS_B_REL 12
`define IMS_B_GRD 11
`define IMS_B_A10 10
`define IMS_B_GCA 7
`define IMS_B_SCE 6
`define IMS_B_AKV 5
`define IMS_B_AKR 4
`define IMS_B_RXR 3
`define IMS_B_SPR 2
`define IMS_B_RSR 1
`define IMS_B_SRQ 0
// ==================================================
// control_high and status fields
`define IMS_B_AHLD 1
`define IMS_B_DHLD 0
`define IMS_B_CLSH 7
`define IMS_B_OVF 6
// ==================================================
// address patterns
`define IMS_GC_ADDR 8'h00
`define IMS_HDR10 5'h1e
`endif

// ==== sim/ims_chk_sva.sv ====
// assertion checker for the two-wire bus controller
`timescale 1ns/10ps
module ims_chk_sva #(
  parameter BRGW = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [15:0] rdata_q,
  input wire cpu_idle,
  input wire scl_in,
  input wire scl_out_q,
  input wire scl_oe_q,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_q,
  input wire pin_owner_q,
  input wire slv_evt_q
);
  // ==================================================
  // shadow state from the register port
  reg [BRGW-1:0] brg_q;
  reg halt_q;
  reg [7:0] lo_cnt_q;
  // saturating count of released clock cycles; 255 marks a long idle bus
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      brg_q <= {BRGW{1'b0}};
      halt_q <= 1'b0;
      lo_cnt_q <= 8'hff;
    end
    else
    begin
      if (wr_stb && addr == 3'h4)
        brg_q <= wdata[BRGW-1:0];
      if (wr_stb && addr == 3'h0)
        halt_q <= wdata[13];
      lo_cnt_q <= scl_oe_q ? 8'h00 : ((lo_cnt_q == 8'hff) ? lo_cnt_q : lo_cnt_q + 8'h01);
    end
  end
  // ==================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  scl_half_a: assert property (
    $rose(scl_oe_q) && pin_owner_q && lo_cnt_q < 8'hc8 |-> lo_cnt_q == brg_q + 2)
    else $error("released clock phase has wrong length");
  start_order_a: assert property (
    $rose(scl_oe_q) && lo_cnt_q == 8'hff |-> sda_oe_q)
    else $error("clock pulled before data at start");
  owner_pins_a: assert property (
    !pin_owner_q |-> !scl_oe_q && !sda_oe_q)
    else $error("pins driven while not owned");
  owner_follow_a: assert property (
    wr_stb && addr == 3'h0 |-> ##2 pin_owner_q == $past(wdata[15], 2))
    else $error("pin ownership does not follow enable");
  rd_idle_a: assert property (
    !$past(rd_stb) |-> rdata_q == 16'h0000)
    else $error("read data outside read slot");
  rd_unimpl_a: assert property (
    $past(rd_stb) && $past(addr) == 3'h0 |-> (rdata_q & 16'h4300) == 16'h0000)
    else $error("unused control bits read nonzero");
  od_low_a: assert property (
    scl_out_q == 1'b0 && sda_out_q == 1'b0)
    else $error("open drain output drives high");
  idle_freeze_a: assert property (
    cpu_idle && halt_q && $past(cpu_idle) && $past(halt_q) |=> $stable(scl_oe_q) && $stable(sda_oe_q))
    else $error("bus moved while halted in idle");
  evt_pulse_a: assert property (
    slv_evt_q |=> !slv_evt_q)
    else $error("slave event longer than one cycle");
  c_evt: cover property ($rose(slv_evt_q));
  c_start: cover property ($rose(scl_oe_q) && lo_cnt_q == 8'hff);
  c_halt: cover property (cpu_idle && halt_q);
endmodule // ims_chk_sva
bind ims_ctrl ims_chk_sva #(.BRGW(BRGW)) i_ims_chk_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata_q(rdata_q), .cpu_idle(cpu_idle), .scl_in(scl_in), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q),
  .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .pin_owner_q(pin_owner_q),
  .slv_evt_q(slv_evt_q));

// ==== sim/ims_bus_model.sv ====
// behavioural far party on the two bus wires
`timescale 1ns/10ps
module ims_bus_model (
  input wire ref_clk,
  input wire scl_oe,
  input wire sda_oe,
  output wire scl_w,
  output wire sda_w,
  output reg [8:0] cap = 9'h000
);
  reg scl_pd = 1'b0;
  reg sda_pd = 1'b0;
  // ==================================================
  // wire resolution: pull-ups, so a released line reads high
  assign scl_w = !(scl_oe || scl_pd);
  assign sda_w = !(sda_oe || sda_pd);
  always @(posedge scl_w)
    cap <= {cap[7:0], sda_w};
  // ==================================================
  // external master sequences, half period of 8 cycles
  task hp;
    repeat (8) @(posedge ref_clk);
  endtask
  task xstart;
    sda_pd <= 1'b1;
    hp;
    scl_pd <= 1'b1;
    hp;
  endtask
  task xbyte(input logic [7:0] b, output logic ackd);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pd <= !b[i];
      hp;
      scl_pd <= 1'b0;
      hp;
      scl_pd <= 1'b1;
      // one cycle of data hold after the falling clock
      @(posedge ref_clk);
    end
    sda_pd <= 1'b0;
    hp;
    scl_pd <= 1'b0;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    ackd = !sda_w;
    @(posedge ref_clk);
    scl_pd <= 1'b1;
    hp;
  endtask
  task xstop;
    sda_pd <= 1'b1;
    hp;
    scl_pd <= 1'b0;
    hp;
    sda_pd <= 1'b0;
    hp;
  endtask
endmodule // ims_bus_model

// ==== sim/tb.sv ====
// self-checking bench for the two-wire bus controller
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [9:0] msk;
    logic [9:0] own;
    logic [15:0] ctl;
    logic [7:0] adr;
    logic ack;
  } ims_row_t;
  ims_row_t rows [0:9];
  reg ref_clk, rst_b, wr_stb, rd_stb, cpu_idle;
  reg [2:0] addr;
  reg [15:0] wdata;
  wire [15:0] rdata_q;
  wire [8:0] cap;
  wire scl_oe_q, sda_oe_q, scl_w, sda_w, pin_owner_q, slv_evt_q;
  int err_count, checked, evt_cnt, e0;
  logic [15:0] d;
  logic ak;
  // ==================================================
  // design and far party
  ims_ctrl #(.BRGW(16)) i_ims_ctrl (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata_q(rdata_q), .cpu_idle(cpu_idle), .scl_in(scl_w), .scl_out_q(), .scl_oe_q(scl_oe_q),
    .sda_in(sda_w), .sda_out_q(), .sda_oe_q(sda_oe_q), .pin_owner_q(pin_owner_q), .slv_evt_q(slv_evt_q));
  ims_bus_model i_ims_bus_model (
    .ref_clk(ref_clk), .scl_oe(scl_oe_q), .sda_oe(sda_oe_q), .scl_w(scl_w), .sda_w(sda_w), .cap(cap));
  // ==================================================
  // helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task rc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    chk(rdata_q & m, exp);
  endtask
  // request bits clear by hardware; bounded wait
  task poll(input int b, output logic v);
    v = 1'b1;
    repeat (300)
      if (v)
      begin
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= 3'h0;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        v = rdata_q[b];
      end
  endtask
  task print_verdict;
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==================================================
  // clock, watchdog, event capture
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    print_verdict;
  end
  // count events so each row checks exactly how many pulses it caused
  always @(posedge ref_clk)
    if (slv_evt_q)
      evt_cnt <= evt_cnt + 1;
  // ==================================================
  // main sequence
  initial
  begin
    rows[0] = '{10'h000, 10'h052, 16'h8000, 8'ha4, 1'b1};
    rows[1] = '{10'h000, 10'h052, 16'h8000, 8'ha6, 1'b0};
    rows[2] = '{10'h001, 10'h052, 16'h8000, 8'ha6, 1'b1};
    rows[3] = '{10'h001, 10'h052, 16'h8800, 8'ha6, 1'b0};
    rows[4] = '{10'h000, 10'h052, 16'h8080, 8'h00, 1'b1};
    rows[5] = '{10'h000, 10'h052, 16'h8800, 8'h00, 1'b0};
    rows[6] = '{10'h000, 10'h052, 16'h8000, 8'h04, 1'b1};
    rows[7] = '{10'h000, 10'h07c, 16'h8800, 8'hf8, 1'b0};
    rows[8] = '{10'h000, 10'h252, 16'h8400, 8'hf4, 1'b1};
    rows[9] = '{10'h000, 10'h052, 16'h8000, 8'hf4, 1'b0};
    rst_b = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    cpu_idle = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rc(3'h0, 16'hffff, 16'h1000);
    foreach (rows[i])
    begin
      wr(3'h5, {6'h00, rows[i].own});
      wr(3'h3, {6'h00, rows[i].msk});
      wr(3'h0, rows[i].ctl);
      e0 = evt_cnt;
      i_ims_bus_model.xstart();
      i_ims_bus_model.xbyte(rows[i].adr, ak);
      i_ims_bus_model.xstop();
      chk({15'h0000, ak}, {15'h0000, rows[i].ack});
      chk(16'(evt_cnt - e0), {15'h0000, rows[i].ack});
    end
    // start held off while halted in idle, then one byte at rate register 3, reload 4
    wr(3'h4, 16'h0003);
    cpu_idle <= 1'b1;
    wr(3'h0, 16'ha001);
    repeat (40) @(posedge ref_clk);
    rc(3'h0, 16'h0001, 16'h0001);
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    poll(0, ak);
    chk({15'h0000, ak}, 16'h0000);
    wr(3'h6, 16'h00a5);
    wr(3'h6, 16'h005a);
    repeat (110) @(posedge ref_clk);
    rc(3'h2, 16'hc080, 16'h8080);
    chk({7'h00, cap}, {7'h00, 8'ha5, 1'b1});
    wr(3'h0, 16'ha004);
    poll(2, ak);
    chk({15'h0000, ak}, 16'h0000);
    // data pin lags the request bit by two flops
    repeat (3) @(negedge ref_clk);
    chk({14'h0000, scl_w, sda_w}, 16'h0003);
    // release bit versus stretch allow and enable
    // a written zero sticks only if stretch allow was already set
    wr(3'h0, 16'h9040);
    wr(3'h0, 16'h8040);
    rc(3'h0, 16'hffff, 16'h8040);
    wr(3'h0, 16'h0040);
    rc(3'h0, 16'hffff, 16'h1040);
    wr(3'h0, 16'h9000);
    wr(3'h0, 16'h8000);
    rc(3'h0, 16'hffff, 16'h9000);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rc(3'h0, 16'hffff, 16'h1000);
    print_verdict;
  end
endmodule // tb
